// ### rtl/stepper_pkg.sv
package stepper_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CHANNELS = 3;
  localparam int NIB_W = 4;
  localparam int IDX_W = 3;
  localparam int CNT_W = 16;
  localparam int HOLD_W = 8;
  localparam int RATE_W = 16;
  localparam int ACC_W = 25;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ_DEF = 20_000_000;
  localparam logic [RATE_W-1:0] RATE_MIN = 16'h000A;
  localparam logic [RATE_W-1:0] RATE_MAX = 16'h0FA0;
  localparam logic [RATE_W-1:0] RATE_RST = 16'h0064;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and field positions
  // ----------------------------------------------------------------
  localparam logic [ADR_W-1:0] OFS_CONFIG = 8'h00;
  localparam logic [ADR_W-1:0] OFS_RATE = 8'h04;
  localparam logic [ADR_W-1:0] OFS_ENABLE = 8'h08;
  localparam logic [ADR_W-1:0] OFS_CMD = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h10;
  localparam logic [ADR_W-1:0] OFS_REMAIN0 = 8'h14;
  localparam logic [ADR_W-1:0] OFS_STOP = 8'h20;
  localparam logic [ADR_W-1:0] OFS_STRIDE = 8'h04;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_HOLD_LSB = 8;
  localparam int CMD_DIR_BIT = 16;
  localparam int CMD_CH_LSB = 17;
  localparam int STAT_DRV_LSB = 4;
  localparam int REM_IDX_LSB = 16;

  // Drive modes; the spare code is refused on write
  typedef enum logic [1:0] {MODE_SINGLE, MODE_DUAL, MODE_HALF, MODE_SPARE} drive_mode_t;

  // Half-step table; bit 3 = C, bit 2 = D, bit 1 = B, bit 0 = A
  // Even entries form the single-winding walk, odd ones the dual walk
  localparam logic [7:0][NIB_W-1:0] HALF_TABLE =
    {4'h5, 4'h4, 4'h6, 4'h2, 4'hA, 4'h8, 4'h9, 4'h1};

  // Pattern shown for a table position in a given mode
  function automatic logic [NIB_W-1:0] pattern_of(input drive_mode_t mode,
                                                  input logic [IDX_W-1:0] idx);
    logic [IDX_W-1:0] pos;
    pos = idx;
    case (mode)
      MODE_HALF: pos = idx;
      MODE_DUAL: pos = {idx[1:0], 1'b1};
      default: pos = {idx[1:0], 1'b0};
    endcase
    return HALF_TABLE[pos];
  endfunction

  // Next table position; narrow counters wrap by themselves
  function automatic logic [IDX_W-1:0] next_index(input drive_mode_t mode,
                                                  input logic [IDX_W-1:0] idx,
                                                  input logic rev);
    logic [IDX_W-1:0] nx;
    nx = idx;
    if (mode == MODE_HALF) begin
      nx = rev ? IDX_W'(idx - 1'b1) : IDX_W'(idx + 1'b1);
    end else begin
      nx = {1'b0, rev ? 2'(idx[1:0] - 1'b1) : 2'(idx[1:0] + 1'b1)};
    end
    return nx;
  endfunction

endpackage

// ### rtl/step_channel.sv
`timescale 1ns/10ps
module step_channel
  import stepper_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic step_en,
  input wire drive_mode_t mode,
  input wire logic [HOLD_W-1:0] hold_len,
  input wire logic start,
  input wire logic [CNT_W-1:0] start_count,
  input wire logic start_rev,
  input wire logic abort,
  input wire logic kill,
  output logic [NIB_W-1:0] drive_q,
  output logic drive_oe_n,
  output logic busy,
  output logic [CNT_W-1:0] remain,
  output logic [IDX_W-1:0] index
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CH_IDLE, CH_RUN, CH_HOLD} ch_state_t;

  typedef struct packed {
    ch_state_t st; // Sequencer phase
    logic [IDX_W-1:0] idx; // Next table entry to show
    logic [CNT_W-1:0] cnt; // Steps still to go
    logic [HOLD_W-1:0] hold; // Braking periods left
    logic rev; // Walk backwards
    logic [NIB_W-1:0] q; // Pattern on the port
    logic oe_n; // Low while the port is driven
  } ch_t;

  ch_t s_r; // Registered state
  ch_t s_nxt; // Next state

  // Next-state logic; step_en is the only thing that moves the table
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      CH_IDLE: begin
        // A zero count leaves the port untouched
        if (start && start_count != '0) begin
          s_nxt.st = CH_RUN;
          s_nxt.cnt = start_count;
          s_nxt.rev = start_rev;
        end
      end
      CH_RUN: begin
        if (kill) begin
          s_nxt.st = CH_IDLE;
          s_nxt.oe_n = 1'b1;
        end else if (abort) begin
          // Early stop still brakes on the last pattern
          s_nxt.st = CH_HOLD;
          s_nxt.hold = hold_len;
        end else if (step_en) begin
          // Index is kept between runs, so a run starts anywhere
          s_nxt.q = pattern_of(mode, s_r.idx);
          s_nxt.oe_n = 1'b0;
          s_nxt.idx = next_index(mode, s_r.idx, s_r.rev);
          s_nxt.cnt = CNT_W'(s_r.cnt - 1'b1);
          if (s_r.cnt == CNT_W'(1)) begin
            s_nxt.st = CH_HOLD;
            s_nxt.hold = hold_len;
          end
        end
      end
      CH_HOLD: begin
        if (kill) begin
          s_nxt.st = CH_IDLE;
          s_nxt.oe_n = 1'b1;
        end else if (step_en) begin
          if (s_r.hold == '0) begin
            s_nxt.st = CH_IDLE;
            s_nxt.oe_n = 1'b1;
          end else begin
            s_nxt.hold = HOLD_W'(s_r.hold - 1'b1);
          end
        end
      end
      default: begin
        s_nxt.st = CH_IDLE;
        s_nxt.oe_n = 1'b1;
      end
    endcase
  end

  // State register; reset leaves the port released
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign drive_q = s_r.q;
  assign drive_oe_n = s_r.oe_n;
  assign busy = (s_r.st != CH_IDLE);
  assign remain = s_r.cnt;
  assign index = s_r.idx;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking

  sequence run_step_s;
    s_r.st == CH_RUN && step_en && !kill && !abort;
  endsequence

  idle_release_a: assert property (disable iff (sys_rst)
    s_r.st == CH_IDLE |-> s_r.oe_n) else $error("idle port still driven");
  step_count_a: assert property (disable iff (sys_rst)
    run_step_s |=> s_r.cnt == CNT_W'($past(s_r.cnt) - 1'b1) && !s_r.oe_n)
    else $error("step did not count down");
  single_onehot_a: assert property (disable iff (sys_rst)
    run_step_s ##0 mode == MODE_SINGLE |=> $onehot(s_r.q))
    else $error("single mode drove other than one winding");
  dual_two_a: assert property (disable iff (sys_rst)
    run_step_s ##0 mode == MODE_DUAL |=> $countones(s_r.q) == 2)
    else $error("dual mode drove other than two windings");
  half_wrap_a: assert property (disable iff (sys_rst)
    run_step_s ##0 mode == MODE_HALF && !s_r.rev |=>
    s_r.idx == IDX_W'($past(s_r.idx) + 1'b1)) else $error("half step order broken");
  zero_count_a: assert property (disable iff (sys_rst)
    s_r.st == CH_IDLE && start && start_count == '0 |=> s_r.st == CH_IDLE && s_r.oe_n)
    else $error("zero count changed the port");
  hold_end_a: assert property (disable iff (sys_rst)
    s_r.st == CH_HOLD && step_en && !kill && s_r.hold == '0 |=>
    s_r.st == CH_IDLE ##1 s_r.oe_n) else $error("hold did not release");
  reset_idle_a: assert property (
    sys_rst |=> s_r.st == CH_IDLE && s_r.cnt == '0 && s_r.oe_n)
    else $error("reset did not idle channel");

endmodule

// ### rtl/stepper_sequencer.sv
`timescale 1ns/10ps
// Notes on behaviour
// - One 4-bit nibble per step per motor
// - Bits 3..0 drive windings C, D, B, A
// - Single mode walks 0001 1000 0010 0100
// - Reverse direction walks the table backwards
// - Dual mode walks 1001 1010 0110 0101
// - Half step walks eight interleaved entries
// - Table wraps after its last entry
// - Runs start at the stored entry
// - Rate ten to four thousand steps per second
// - Hold last pattern 0-255 periods, then release
// - Count up to 65535; zero does nothing
// - Three channels, each its own port nibble
module stepper_sequencer
  import stepper_pkg::*;
#(
  parameter int unsigned CLK_HZ = CLK_HZ_DEF
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [CHANNELS*NIB_W-1:0] drive_q,
  output logic [CHANNELS-1:0] drive_oe_n
);

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  // Accumulator wraps at the clock rate; one wrap is one step period
  localparam logic [ACC_W-1:0] ACC_TOP = ACC_W'(CLK_HZ);
  // Fewest cycles between two steps at the fastest rate
  localparam int MIN_GAP = CLK_HZ / RATE_MAX;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    drive_mode_t mode; // Shared drive mode
    logic [HOLD_W-1:0] hold; // Shared braking periods
    logic [RATE_W-1:0] rate; // Steps per second
    logic [CHANNELS-1:0] ena; // Channel enables
    logic [ACC_W-1:0] acc; // Rate accumulator
    logic step_en; // One-cycle step pulse
    logic [CHANNELS-1:0] start; // One-cycle run requests
    logic [CNT_W-1:0] count; // Count for the request
    logic rev; // Direction for the request
    logic [CHANNELS-1:0] abort; // One-cycle stop requests
    logic ack; // Bus acknowledge
    logic [DAT_W-1:0] dat; // Bus read data
  } top_t;

  top_t t_r; // Registered state
  top_t t_nxt; // Next state

  // Channel views
  logic [CHANNELS-1:0] ch_busy; // Channel not idle
  logic [CHANNELS-1:0][CNT_W-1:0] ch_remain; // Steps still to go
  logic [CHANNELS-1:0][IDX_W-1:0] ch_index; // Next table entry

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge of a write into an old word
  function automatic logic [DAT_W-1:0] merge(input logic [DAT_W-1:0] old,
                                             input logic [DAT_W-1:0] wd,
                                             input logic [SEL_W-1:0] sel);
    logic [DAT_W-1:0] res;
    res = old;
    for (int b = 0; b < SEL_W; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Keeps the rate inside the drivable range
  function automatic logic [RATE_W-1:0] clamp_rate(input logic [RATE_W-1:0] rq);
    logic [RATE_W-1:0] res;
    res = rq;
    if (rq < RATE_MIN) begin
      res = RATE_MIN;
    end else if (rq > RATE_MAX) begin
      res = RATE_MAX;
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Bus slave and step divider
  // ----------------------------------------------------------------
  // Request is taken on the edge where it is seen and ack is low
  logic req; // New bus request
  logic [ADR_W-1:0] word_adr; // Byte address with lanes stripped
  logic [DAT_W-1:0] cfg_view; // Config as a bus word
  logic [DAT_W-1:0] wr_word; // Merged write word
  logic [CHANNELS-1:0] stop_bits; // Stop lanes of a write

  assign req = wb_cyc_i && wb_stb_i && !t_r.ack;
  assign word_adr = {wb_adr_i[ADR_W-1:2], 2'b00};

  // Next state for registers, divider and bus answer
  always_comb begin
    logic [ACC_W-1:0] acc_sum;
    acc_sum = '0;
    t_nxt = t_r;
    t_nxt.start = '0;
    t_nxt.abort = '0;
    t_nxt.ack = req;
    cfg_view = '0;
    cfg_view[CFG_MODE_LSB +: 2] = t_r.mode;
    cfg_view[CFG_HOLD_LSB +: HOLD_W] = t_r.hold;
    wr_word = '0;
    stop_bits = '0;

    // Phase accumulator gives an exact average rate without a divider
    acc_sum = ACC_W'(t_r.acc + ACC_W'(t_r.rate));
    t_nxt.step_en = 1'b0;
    if (acc_sum >= ACC_TOP) begin
      t_nxt.acc = ACC_W'(acc_sum - ACC_TOP);
      t_nxt.step_en = 1'b1;
    end else begin
      t_nxt.acc = acc_sum;
    end

    // Writes
    if (req && wb_we_i) begin
      case (word_adr)
        OFS_CONFIG: begin
          wr_word = merge(cfg_view, wb_dat_i, wb_sel_i);
          // Spare mode code is refused and the old mode kept
          if (drive_mode_t'(wr_word[CFG_MODE_LSB +: 2]) != MODE_SPARE) begin
            t_nxt.mode = drive_mode_t'(wr_word[CFG_MODE_LSB +: 2]);
          end
          t_nxt.hold = wr_word[CFG_HOLD_LSB +: HOLD_W];
        end
        OFS_RATE: begin
          wr_word = merge(DAT_W'(t_r.rate), wb_dat_i, wb_sel_i);
          t_nxt.rate = clamp_rate(wr_word[RATE_W-1:0]);
        end
        OFS_ENABLE: begin
          wr_word = merge(DAT_W'(t_r.ena), wb_dat_i, wb_sel_i);
          t_nxt.ena = wr_word[CHANNELS-1:0];
        end
        OFS_CMD: begin
          wr_word = merge('0, wb_dat_i, wb_sel_i);
          t_nxt.count = wr_word[CNT_W-1:0];
          t_nxt.rev = wr_word[CMD_DIR_BIT];
          // Runs on a disabled or busy channel are ignored
          for (int c = 0; c < CHANNELS; c++) begin
            if (wr_word[CMD_CH_LSB +: 2] == 2'(c) && t_r.ena[c] && !ch_busy[c]) begin
              t_nxt.start[c] = 1'b1;
            end
          end
        end
        OFS_STOP: begin
          wr_word = merge('0, wb_dat_i, wb_sel_i);
          stop_bits = wr_word[CHANNELS-1:0];
          t_nxt.abort = stop_bits;
        end
        default: begin
          // Unmapped or read-only word: write is dropped
        end
      endcase
    end

    // Reads; unmapped words read as zero
    t_nxt.dat = '0;
    if (req && !wb_we_i) begin
      case (word_adr)
        OFS_CONFIG: t_nxt.dat = cfg_view;
        OFS_RATE: t_nxt.dat = DAT_W'(t_r.rate);
        OFS_ENABLE: t_nxt.dat = DAT_W'(t_r.ena);
        OFS_STATUS: begin
          t_nxt.dat[CHANNELS-1:0] = ch_busy;
          t_nxt.dat[STAT_DRV_LSB +: CHANNELS] = ~drive_oe_n;
        end
        default: begin
          for (int c = 0; c < CHANNELS; c++) begin
            if (word_adr == ADR_W'(OFS_REMAIN0 + ADR_W'(c) * OFS_STRIDE)) begin
              t_nxt.dat[CNT_W-1:0] = ch_remain[c];
              t_nxt.dat[REM_IDX_LSB +: IDX_W] = ch_index[c];
            end
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      t_r <= '0;
      t_r.rate <= RATE_RST;
    end else begin
      t_r <= t_nxt;
    end
  end

  // Answer and read data come straight from the state register
  assign wb_ack_o = t_r.ack;
  assign wb_dat_o = t_r.dat;

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  // Disabling a channel drops its port at once, without braking
  for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
    step_channel u_ch (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .step_en(t_r.step_en),
      .mode(t_r.mode),
      .hold_len(t_r.hold),
      .start(t_r.start[g]),
      .start_count(t_r.count),
      .start_rev(t_r.rev),
      .abort(t_r.abort[g]),
      .kill(!t_r.ena[g]),
      .drive_q(drive_q[g*NIB_W +: NIB_W]),
      .drive_oe_n(drive_oe_n[g]),
      .busy(ch_busy[g]),
      .remain(ch_remain[g]),
      .index(ch_index[g])
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Cycles since the last step pulse, saturating
  logic [ACC_W-1:0] gap_r;
  logic seen_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      gap_r <= '0;
      seen_r <= 1'b0;
    end else begin
      if (t_r.step_en) begin
        gap_r <= '0;
        seen_r <= 1'b1;
      end else if (gap_r != '1) begin
        gap_r <= ACC_W'(gap_r + 1'b1);
      end
      // A rate write may legally pull the next step in, so restart the watch
      if (t_nxt.rate != t_r.rate) begin
        seen_r <= 1'b0;
      end
    end
  end

  // Request seen while no answer is pending
  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  // Stop on channel 1 while it drives, with no step pulse in the same cycle
  sequence stop_req_s;
    t_r.abort[1] && t_r.ena[1] && ch_busy[1] && !drive_oe_n[1] && !t_r.step_en;
  endsequence

  // Fresh run on channel 0, then a cycle without a step pulse
  sequence run_start_s;
    (t_r.start[0] && t_r.count != '0 && !ch_busy[0]) ##1 !t_r.step_en;
  endsequence

  // One answer per request; a request held through the answer is not retaken
  ack_follow_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    bus_req_s |=> wb_ack_o ##1 !wb_ack_o) else $error("bus answer not one pulse");
  // Read data is zero outside the answer cycle, so no stale word leaks out
  dat_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !wb_ack_o |-> wb_dat_o == '0) else $error("read data outside answer");
  // Clamping on write keeps every stored rate drivable
  rate_range_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    t_r.rate >= RATE_MIN && t_r.rate <= RATE_MAX) else $error("rate out of range");
  // Steps never come closer than the fastest legal rate allows
  step_gap_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    t_r.step_en && seen_r |-> gap_r >= ACC_W'(MIN_GAP - 1)) else $error("steps too close");
  // The refused mode code never reaches the channels
  mode_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    t_r.mode != MODE_SPARE) else $error("spare mode code taken");
  // Runs only start on enabled channels
  start_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (t_r.start & ~t_r.ena) == '0) else $error("run started on disabled channel");
  // A run waits for the next step pulse before it shows anything
  run_start_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    run_start_s |=> $stable(drive_q[NIB_W-1:0])) else $error("run moved before a step");
  // Stop brakes on the last pattern instead of dropping the port
  stop_brake_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    stop_req_s |=> ch_busy[1] && !drive_oe_n[1]) else $error("stop skipped the brake");
  // Disabling drops the port at once, without braking
  drop_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(t_r.ena[0]) |=> drive_oe_n[0]) else $error("disabled channel still drives");

endmodule

// ### testbench/winding_driver.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Power stage stand-in: what each set of windings sees
// ----------------------------------------------------------------
module winding_driver
  import stepper_pkg::*;
(
  input wire logic [CHANNELS*NIB_W-1:0] drive_q,
  input wire logic [CHANNELS-1:0] drive_oe_n,
  output logic [CHANNELS*NIB_W-1:0] coil
);
  // Driver inputs sit on pull-downs, so a released port leaves all coils off
  always_comb begin
    for (int n = 0; n < CHANNELS; n++) begin
      // Bit 3 C, bit 2 D, bit 1 B, bit 0 A, wired straight through
      coil[n*NIB_W +: NIB_W] = drive_oe_n[n] ? 4'h0 : drive_q[n*NIB_W +: NIB_W];
    end
  end
endmodule

// ### testbench/stepper_phase_sequencer_tb.sv
`timescale 1ns/10ps
module stepper_phase_sequencer_tb
  import stepper_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int PER = 10; // Cycles per step: 4000 steps/s on the short clock
  localparam int LIMIT = 60000; // Cycle ceiling for the whole run
  // Interleaved walk, kept here apart from the design's copy
  localparam logic [7:0][3:0] TBL = {4'h5, 4'h4, 4'h6, 4'h2, 4'hA, 4'h8, 4'h9, 4'h1};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [ADR_W-1:0] wb_adr_i = 8'h00;
  logic [SEL_W-1:0] wb_sel_i = 4'h0;
  logic [DAT_W-1:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [11:0] drive_q, coil;
  logic [2:0] drive_oe_n;
  logic [2:0] idx [3] = '{default: 3'h0}; // Expected next entry per channel
  logic [1:0] cur_mode = 2'h0; // Mode last written
  int hold_v = 0; // Hold length last written
  int mismatches = 0, checks = 0, cycles = 0;

  // ----------------------------------------------------------------
  // Design, power stage, clock and watchdog
  // ----------------------------------------------------------------
  // Short clock figure keeps step periods at ten cycles
  stepper_sequencer #(.CLK_HZ(40000)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .drive_q(drive_q), .drive_oe_n(drive_oe_n));
  winding_driver drv_u (.drive_q(drive_q), .drive_oe_n(drive_oe_n), .coil(coil));
  always #25 ref_clk = ~ref_clk;
  // A hang counts as a mismatch and closes the run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Comparisons and verdict
  // ----------------------------------------------------------------
  task automatic cmp_w(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_n(input string what, input logic [3:0] exp, input logic [3:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Expectation helpers
  // ----------------------------------------------------------------
  // Four-entry modes pick even or odd entries of the long walk
  function automatic logic [3:0] exp_pat(input logic [2:0] i);
    if (cur_mode == 2'h2) return TBL[i];
    return TBL[{i[1:0], cur_mode[0]}];
  endfunction
  function automatic logic [2:0] nxt(input logic [2:0] i, input logic rev);
    if (cur_mode == 2'h2) return rev ? i - 3'h1 : i + 3'h1;
    return {1'b0, rev ? i[1:0] - 2'h1 : i[1:0] + 2'h1};
  endfunction

  // ----------------------------------------------------------------
  // Bus and run tasks
  // ----------------------------------------------------------------
  // Single classic cycle; request held until ack is seen at an edge
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    // Ack and data are read at the edge itself, before that edge's updates land
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    cmp_w("bus ack", 32'h1, {31'h0, wb_ack_o});
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string what);
    wb_xfer(1'b0, adr, 32'h0);
    cmp_w(what, exp, rd);
  endtask
  // Sample a little after the edge so the edge's updates have landed
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic set_cfg(input logic [1:0] m, input int h);
    cur_mode = m;
    hold_v = h;
    wb_xfer(1'b1, OFS_CONFIG, {16'h0, 8'(h), 6'h0, m});
  endtask
  // One run: every pattern, its spacing, the hold and the stored entry
  task automatic run(input logic [1:0] ch, input logic [15:0] n, input logic rev);
    int k;
    wb_xfer(1'b1, OFS_CMD, {13'h0, ch, rev, n});
    k = 0;
    do begin
      tick();
      k++;
    end while (drive_oe_n[ch] && k < 3 * PER);
    if (n == 0) begin
      cmp_w("idle ports", 32'h7, {29'h0, drive_oe_n});
      return;
    end
    for (int s = 0; s < n; s++) begin
      if (s > 0) repeat (PER) tick();
      cmp_n("pattern", exp_pat(idx[ch]), coil[ch*4 +: 4]);
      cmp_w("port enables", 32'h7 ^ (32'h1 << ch), {29'h0, drive_oe_n});
      idx[ch] = nxt(idx[ch], rev);
    end
    k = 0;
    do begin
      tick();
      k++;
    end while (!drive_oe_n[ch] && k < 3000);
    cmp_w("hold cycles", 32'((hold_v + 1) * PER), 32'(k));
    rd_chk(OFS_REMAIN0 + 8'(ch) * OFS_STRIDE, {13'h0, idx[ch], 16'h0}, "remain");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(35));
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk(OFS_CONFIG, 32'h0, "config");
    rd_chk(OFS_RATE, 32'h64, "rate");
    rd_chk(OFS_REMAIN0, 32'h0, "remain");
    rd_chk(8'h40, 32'h0, "unmapped");
    cmp_w("ports after reset", 32'h7, {29'h0, drive_oe_n});
    wb_xfer(1'b1, OFS_RATE, 32'h5);
    rd_chk(OFS_RATE, 32'hA, "rate floor");
    wb_xfer(1'b1, OFS_RATE, 32'h1388);
    rd_chk(OFS_RATE, 32'hFA0, "rate ceiling");
    wb_xfer(1'b1, OFS_ENABLE, 32'h7);
    // Corner runs: wraps, reverse walks, mid-table starts, empty count
    set_cfg(2'h0, 0);
    run(2'h0, 16'h6, 1'b0);
    run(2'h1, 16'h5, 1'b1);
    set_cfg(2'h1, 1);
    run(2'h2, 16'h5, 1'b0);
    set_cfg(2'h2, 3);
    run(2'h0, 16'h9, 1'b0);
    run(2'h0, 16'h3, 1'b1);
    run(2'h1, 16'h0, 1'b0);
    // Shared port: the leftover walk completes a full turn, mode unchanged
    run(2'h2, 16'h3, 1'b0);
    run(2'h2, 16'h5, 1'b0);
    // Spare mode code is refused and the old mode kept
    wb_xfer(1'b1, OFS_CONFIG, {16'h0, 8'h03, 6'h0, 2'h3});
    rd_chk(OFS_CONFIG, {16'h0, 8'h03, 6'h0, 2'h2}, "spare mode");
    // Early stop brakes on the first pattern and keeps the remaining count
    wb_xfer(1'b1, OFS_CMD, {13'h0, 2'h1, 1'b0, 16'h14});
    do tick(); while (drive_oe_n[1]);
    cmp_n("stop pattern", exp_pat(idx[1]), coil[7:4]);
    idx[1] = nxt(idx[1], 1'b0);
    wb_xfer(1'b1, OFS_STOP, 32'h2);
    rd_chk(OFS_STATUS, 32'h22, "status in hold");
    do tick(); while (!drive_oe_n[1]);
    rd_chk(OFS_REMAIN0 + OFS_STRIDE, {13'h0, idx[1], 16'h13}, "remain after stop");
    // Disabling a channel drops its port at once and ends the run
    wb_xfer(1'b1, OFS_CMD, {13'h0, 2'h0, 1'b1, 16'h14});
    do tick(); while (drive_oe_n[0]);
    cmp_n("kill pattern", exp_pat(idx[0]), coil[3:0]);
    idx[0] = nxt(idx[0], 1'b1);
    wb_xfer(1'b1, OFS_ENABLE, 32'h6);
    tick();
    cmp_w("ports after disable", 32'h7, {29'h0, drive_oe_n});
    rd_chk(OFS_STATUS, 32'h0, "status after disable");
    wb_xfer(1'b1, OFS_ENABLE, 32'h7);
    // Random runs, mode and hold changed between them
    repeat (8) begin
      set_cfg(2'($urandom_range(2)), $urandom_range(3));
      run(2'($urandom_range(2)), 16'($urandom_range(12, 1)), 1'($urandom));
    end
    end_of_test();
  end
endmodule
